// ### rtl/ffm_defines.svh
// Offsets, field positions, reset values and timing constants
`ifndef FFM_DEFINES_SVH
`define FFM_DEFINES_SVH
// Register indices; byte address is four times the index
`define FFM_IDX_COMMON 8'h17
`define FFM_IDX_TARGET 8'h18
`define FFM_IDX_XHI 8'h73
`define FFM_IDX_XLO 8'h74
`define FFM_IDX_YHI 8'h75
`define FFM_IDX_YLO 8'h76
`define FFM_IDX_ZHI 8'h77
`define FFM_IDX_ZLO 8'h78
`define FFM_IDX_CFG 8'h80
`define FFM_IDX_MODE 8'h81
`define FFM_IDX_STAT 8'h82
`define FFM_IDX_COUNT 8'h83
`define FFM_IDX_ISTA 8'h84
`define FFM_IDX_IMASK 8'h85
`define FFM_RST_8 8'h00
// Field positions
`define FFM_DBCNTM_BIT 7
`define FFM_XYZ_EN_BIT 7
`define FFM_TRANS_EN_BIT 7
`define FFM_CFG_OAE_BIT 3
`define FFM_MODE_HYB_BIT 5
`define FFM_MODE_FS_LSB 6
`define FFM_MODE_PWR_LSB 3
// Common threshold scale, counts per 63 mg step for each range
`define FFM_SCALE_FS0 9'h102
`define FFM_SCALE_FS1 9'h081
`define FFM_SCALE_FS2 9'h041
// Step exponent caps, in powers of two of the 1.25 ms step
`define FFM_EXP_NORMAL_MAX 4'h4
`define FFM_EXP_SLOW 4'h6
`define FFM_EXP_SLOWEST 4'h7
`define FFM_ODR_12HZ 3'h5
`define FFM_ODR_SLOW_FIRST 3'h5
// Timing: base step and clock period in ns
`define FFM_STEP_BASE_NS 1250000
`define FFM_CLK_NS 50
`endif

// ### rtl/ffm_pkg.sv
// Types shared by the freefall/motion detector
`default_nettype none
package ffm_pkg;
  typedef enum logic [1:0] {
    FFM_NORMAL,
    FFM_LOW_POWER_LOW_NOISE_MODE,
    FFM_HIRES,
    FFM_LOWPOWER
  } ffm_pwr_e;
  typedef logic signed [13:0] ffm_acc_t;
  typedef logic [15:0] ffm_thr_t;
endpackage : ffm_pkg
`default_nettype wire

// ### rtl/ffm_detect.sv
// Freefall/motion detector with Avalon-MM register slave
//
// Behaviour
// RULE_01 - Per-axis enable off: all axes use common 7-bit 63 mg threshold.
// RULE_02 - Per-axis enable on: each axis uses its own high/low threshold.
// RULE_03 - Per-axis thresholds are 13-bit, scaled like output data.
// RULE_04 - Software never sets per-axis and transient-share enables together.
// RULE_05 - High register holds bits 12..6; low register holds 5..0 on top.
// RULE_06 - Combine select 0: event when all enabled axes are below threshold.
// RULE_07 - Combine select 1: event when any enabled axis exceeds threshold.
// RULE_08 - 8-bit target sets consecutive qualifying samples needed.
// RULE_09 - Condition lost: clear counter, or decrement if clear mode is 0.
// RULE_10 - Event flag sets when debounce counter equals the target.
// RULE_11 - Debounce counter saturates at the target.
// RULE_12 - Hybrid mode halves the sample rate, doubling every step.
// RULE_13 - Step time follows rate and power mode per the step table.
// RULE_14 - Compare and counter update once per sample, else hold.
// RULE_15 - Threshold and debounce registers reset to zero.
`include "ffm_defines.svh"
`default_nettype none
module ffm_detect #(
  parameter int STEP_BASE_CYC = `FFM_STEP_BASE_NS / `FFM_CLK_NS
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire ffm_pkg::ffm_acc_t accel_x_i,
  input wire ffm_pkg::ffm_acc_t accel_y_i,
  input wire ffm_pkg::ffm_acc_t accel_z_i,
  output logic event_o,
  output logic irq_o
);
  import ffm_pkg::*;

  // ****************************************
  // Register slave
  // ****************************************
  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] common_q, target_q, cfg_q, mode_q, imask_q, ista_q;
  logic [7:0] hi_q [3];
  logic [7:0] lo_q [3];
  logic [7:0] cnt_q, cnt_d;
  logic evt_q, cond_q, irq_q;
  logic [7:0] idx;
  logic wr_en;
  logic [7:0] rd_mux;
  logic [1:0] ista_set;

  assign idx = avs_address_i[9:2];
  // Writes land on the edge where the master sees waitrequest low
  assign wr_en = avs_write_i && !wait_q;

  // One wait state per access keeps read data registered
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_comb begin
    rd_mux = `FFM_RST_8;
    unique case (idx)
      `FFM_IDX_COMMON: rd_mux = common_q;
      `FFM_IDX_TARGET: rd_mux = target_q;
      `FFM_IDX_XHI: rd_mux = hi_q[0];
      `FFM_IDX_XLO: rd_mux = {lo_q[0][7:2], 2'b00};
      `FFM_IDX_YHI: rd_mux = hi_q[1];
      `FFM_IDX_YLO: rd_mux = {lo_q[1][7:2], 2'b00};
      `FFM_IDX_ZHI: rd_mux = {1'b0, hi_q[2][6:0]};
      `FFM_IDX_ZLO: rd_mux = {lo_q[2][7:2], 2'b00};
      `FFM_IDX_CFG: rd_mux = {4'h0, cfg_q[3:0]};
      `FFM_IDX_MODE: rd_mux = mode_q;
      `FFM_IDX_STAT: rd_mux = {6'h00, cond_q, evt_q};
      `FFM_IDX_COUNT: rd_mux = cnt_q;
      `FFM_IDX_ISTA: rd_mux = {6'h00, ista_q[1:0]};
      `FFM_IDX_IMASK: rd_mux = {6'h00, imask_q[1:0]};
      default: rd_mux = `FFM_RST_8;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= {24'h00_0000, rd_mux};
    end
  end

  // Trans-share bit is only stored; software keeps it apart RULE_04
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      common_q <= `FFM_RST_8; // RULE_15
      target_q <= `FFM_RST_8;
      cfg_q <= `FFM_RST_8;
      mode_q <= `FFM_RST_8;
      imask_q <= `FFM_RST_8;
      for (int i = 0; i < 3; i++) begin
        hi_q[i] <= `FFM_RST_8;
        lo_q[i] <= `FFM_RST_8;
      end
    end else if (wr_en) begin
      unique case (idx)
        `FFM_IDX_COMMON: common_q <= avs_writedata_i[7:0];
        `FFM_IDX_TARGET: target_q <= avs_writedata_i[7:0]; // RULE_08
        `FFM_IDX_XHI: hi_q[0] <= avs_writedata_i[7:0];
        `FFM_IDX_XLO: lo_q[0] <= avs_writedata_i[7:0];
        `FFM_IDX_YHI: hi_q[1] <= avs_writedata_i[7:0];
        `FFM_IDX_YLO: lo_q[1] <= avs_writedata_i[7:0];
        `FFM_IDX_ZHI: hi_q[2] <= avs_writedata_i[7:0];
        `FFM_IDX_ZLO: lo_q[2] <= avs_writedata_i[7:0];
        `FFM_IDX_CFG: cfg_q <= avs_writedata_i[7:0];
        `FFM_IDX_MODE: mode_q <= avs_writedata_i[7:0];
        `FFM_IDX_IMASK: imask_q <= avs_writedata_i[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Step timer
  // ****************************************
  logic [2:0] output_data_rate;
  ffm_pwr_e pwr;
  logic [3:0] exp_w;
  logic [31:0] base_q;
  logic [8:0] mult_q;
  logic [8:0] mult_end;
  logic tick_q;

  assign output_data_rate = mode_q[2:0];
  assign pwr = ffm_pwr_e'(mode_q[`FFM_MODE_PWR_LSB +: 2]);

  // Step as a power of two of the fastest step
  always_comb begin
    exp_w = {1'b0, output_data_rate};
    unique case (pwr) // RULE_13
      FFM_NORMAL: begin
        if ({1'b0, output_data_rate} > `FFM_EXP_NORMAL_MAX) exp_w = `FFM_EXP_NORMAL_MAX;
      end
      FFM_LOW_POWER_LOW_NOISE_MODE: begin
        if (output_data_rate >= `FFM_ODR_SLOW_FIRST) exp_w = `FFM_EXP_SLOW;
      end
      FFM_HIRES: begin
        exp_w = {3'b000, output_data_rate != 3'h0};
      end
      FFM_LOWPOWER: begin
        if (output_data_rate == `FFM_ODR_12HZ) exp_w = `FFM_EXP_SLOW;
        else if (output_data_rate > `FFM_ODR_12HZ) exp_w = `FFM_EXP_SLOWEST;
      end
    endcase
    exp_w = exp_w + {3'b000, mode_q[`FFM_MODE_HYB_BIT]}; // RULE_12
  end
  assign mult_end = 9'(9'h001 << exp_w) - 9'h001;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_q <= 32'h0000_0000;
      mult_q <= 9'h000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (base_q >= 32'(STEP_BASE_CYC - 1)) begin
        base_q <= 32'h0000_0000;
        if (mult_q >= mult_end) begin
          mult_q <= 9'h000;
          tick_q <= 1'b1;
        end else begin
          mult_q <= mult_q + 9'h001;
        end
      end else begin
        base_q <= base_q + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // Threshold compare
  // ****************************************
  logic [13:0] acc_abs [3];
  ffm_thr_t thr [3];
  ffm_thr_t common_thr;
  logic [8:0] scale;
  logic [2:0] below, above, axis_en;
  logic xyz_en, oae, cond_w;

  assign xyz_en = hi_q[0][`FFM_XYZ_EN_BIT];
  assign oae = cfg_q[`FFM_CFG_OAE_BIT];
  assign axis_en = cfg_q[2:0];
  assign acc_abs[0] = accel_x_i[13] ? 14'(-accel_x_i) : accel_x_i;
  assign acc_abs[1] = accel_y_i[13] ? 14'(-accel_y_i) : accel_y_i;
  assign acc_abs[2] = accel_z_i[13] ? 14'(-accel_z_i) : accel_z_i;

  always_comb begin
    unique case (mode_q[`FFM_MODE_FS_LSB +: 2])
      2'h0: scale = `FFM_SCALE_FS0;
      2'h1: scale = `FFM_SCALE_FS1;
      default: scale = `FFM_SCALE_FS2;
    endcase
  end
  // Common threshold converted into output-data counts
  // Both factors widened first so the product never wraps at nine bits
  assign common_thr = 16'(common_q[6:0]) * 16'(scale); // RULE_01

  for (genvar a = 0; a < 3; a++) begin : g_axis
    assign thr[a] = xyz_en ? {3'b000, hi_q[a][6:0], lo_q[a][7:2]} // RULE_05
                           : common_thr; // RULE_02 RULE_03
    assign below[a] = {2'b00, acc_abs[a]} < thr[a];
    assign above[a] = {2'b00, acc_abs[a]} > thr[a];
  end

  // No axis enabled never qualifies, even for the all-below case
  assign cond_w = oae ? |(above & axis_en) // RULE_07
                      : ((&(below | ~axis_en)) && |axis_en); // RULE_06

  // ****************************************
  // Debounce counter and event flag
  // ****************************************
  always_comb begin
    cnt_d = cnt_q;
    if (cond_w) begin
      if (cnt_q < target_q) cnt_d = cnt_q + 8'h01;
      else cnt_d = target_q; // RULE_11
    end else if (common_q[`FFM_DBCNTM_BIT]) begin
      cnt_d = 8'h00; // RULE_09
    end else if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01; // RULE_09
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
      evt_q <= 1'b0;
      cond_q <= 1'b0;
    end else if (tick_q) begin // RULE_14
      cnt_q <= cnt_d;
      cond_q <= cond_w;
      evt_q <= cond_w && (cnt_d == target_q); // RULE_10
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  assign ista_set = {evt_q && tick_q && !(cond_w && cnt_d == target_q),
                     !evt_q && tick_q && cond_w && cnt_d == target_q};

  // Set beats a same-cycle write-one clear
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ista_q <= `FFM_RST_8;
      irq_q <= 1'b0;
    end else begin
      if (wr_en && idx == `FFM_IDX_ISTA) begin
        ista_q <= (ista_q & ~avs_writedata_i[7:0]) | {6'h00, ista_set};
      end else begin
        ista_q <= ista_q | {6'h00, ista_set};
      end
      irq_q <= |(ista_q[1:0] & imask_q[1:0]);
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign event_o = evt_q;
  assign irq_o = irq_q;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_step_cond;
    tick_q && cond_w;
  endsequence
  sequence s_step_lost;
    tick_q && !cond_w;
  endsequence

  property p_common;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !xyz_en |-> thr[1] == 16'(common_q[6:0]) * 16'(scale);
  endproperty
  a_common: assert property (p_common) else $error("common thr"); // RULE_01

  property p_indiv;
    @(posedge mclk_i) disable iff (!rst_n_i)
    xyz_en |-> thr[2][12:6] == hi_q[2][6:0] && thr[2][5:0] == lo_q[2][7:2];
  endproperty
  a_indiv: assert property (p_indiv) else $error("axis thr"); // RULE_05

  property p_and;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !oae && cond_w |-> axis_en[0] == 1'b0 || {2'b00, acc_abs[0]} < thr[0];
  endproperty
  a_and: assert property (p_and) else $error("and mode"); // RULE_06

  property p_or;
    @(posedge mclk_i) disable iff (!rst_n_i)
    oae && axis_en[1] && {2'b00, acc_abs[1]} > thr[1] |-> cond_w;
  endproperty
  a_or: assert property (p_or) else $error("or mode"); // RULE_07

  property p_evt;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s_step_cond ##0 (cnt_d == target_q) |=> evt_q && cnt_q == target_q;
  endproperty
  a_evt: assert property (p_evt) else $error("event flag"); // RULE_10

  property p_sat;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s_step_cond ##0 $stable(target_q) |=> cnt_q <= $past(target_q);
  endproperty
  a_sat: assert property (p_sat) else $error("saturation"); // RULE_11

  property p_dec;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s_step_lost ##0 !common_q[7] && cnt_q != 8'h00
      |=> cnt_q == $past(cnt_q) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement"); // RULE_09

  property p_clr;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s_step_lost ##0 common_q[7] |=> cnt_q == 8'h00 && !evt_q;
  endproperty
  a_clr: assert property (p_clr) else $error("clear"); // RULE_09

  property p_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !tick_q |=> $stable(cnt_q) && $stable(evt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("hold"); // RULE_14

  property p_wait;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (avs_read_i || avs_write_i) && wait_q |=> !wait_q ##1 wait_q;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest");
endmodule : ffm_detect
`default_nettype wire

// ### test/ffm_host.sv
// Avalon-MM host model that configures and polls the detector
`default_nettype none
module ffm_host (
  input wire logic mclk_i,
  input wire logic [31:0] rdata_i,
  input wire logic wait_i,
  output logic [9:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [31:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int timeouts = 0;
  initial begin
    addr_o = '0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = '0;
  end
  // ******************************
  // Bus cycles
  // ******************************
  // Request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [7:0] idx,
    input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    addr_o <= {idx, 2'h0};
    wdata_o <= {24'h0, wd};
    wr_o <= w;
    rd_o <= !w;
    @(posedge mclk_i);
    while (wait_i !== 1'b0 && n < 50) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 50) begin
      timeouts++;
    end
    rd = rdata_i[7:0];
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    // Idle edge so the next request never lands in the same step
    @(posedge mclk_i);
  endtask : xfer
  task automatic put(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    if (idx == 8'h75) begin
      d[7] = 1'b0;
    end
    xfer(1'b1, idx, d, unused);
  endtask : put
  task automatic get(input logic [7:0] idx, output logic [7:0] d);
    xfer(1'b0, idx, 8'h00, d);
  endtask : get
endmodule : ffm_host
`default_nettype wire

// ### test/tb_accel_freefall_motion_detect.sv
// Self-checking testbench for the freefall/motion detector
`default_nettype none
module tb_accel_freefall_motion_detect;
  import ffm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic pa;
    logic [7:0] cfg;
    int x;
    int y;
    int z;
    logic ev;
  } ffm_row_s;
  logic mclk;
  logic rst_n;
  logic [9:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic waitreq;
  ffm_acc_t ax;
  ffm_acc_t ay;
  ffm_acc_t az;
  logic event_o;
  logic irq;
  int mismatches = 0;
  int n_checks = 0;
  logic [7:0] d;
  int n;
  // Common threshold 2 is 516 counts; per-axis threshold is 68
  ffm_row_s rows[8] = '{
    '{1'b0, 8'h07, 100, -200, 300, 1'b1},
    '{1'b0, 8'h07, 100, -200, 600, 1'b0},
    '{1'b0, 8'h0F, -600, 0, 0, 1'b1},
    '{1'b0, 8'h0F, 100, 100, 100, 1'b0},
    '{1'b1, 8'h0F, 70, 0, 0, 1'b1},
    '{1'b1, 8'h0F, 68, 0, 0, 1'b0},
    '{1'b1, 8'h07, 69, 0, 0, 1'b0},
    '{1'b1, 8'h0E, 1000, 0, 0, 1'b0}
  };
  logic [7:0] ridx[10] = '{8'h17, 8'h18, 8'h73, 8'h74, 8'h75, 8'h76,
    8'h77, 8'h78, 8'h83, 8'h40};
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Short step keeps every debounce run brief
  ffm_detect #(.STEP_BASE_CYC(4)) DUT (
    .mclk_i(mclk), .rst_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .accel_x_i(ax), .accel_y_i(ay), .accel_z_i(az),
    .event_o(event_o), .irq_o(irq));
  ffm_host HOST (
    .mclk_i(mclk), .rdata_i(rdata), .wait_i(waitreq), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
  // ******************************
  // Checking and verdict
  // ******************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    mismatches += HOST.timeouts;
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic wait_ev(output int k);
    k = 0;
    while (event_o !== 1'b1 && k < 400) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 400) begin
      mismatches++;
    end
  endtask : wait_ev
  // Reads the counter until it leaves the given value
  task automatic poll_cnt(input logic [7:0] old, output logic [7:0] v);
    int k;
    k = 0;
    v = old;
    while (v === old && k < 60) begin
      HOST.get(8'h83, v);
      k++;
    end
  endtask : poll_cnt
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    give_verdict();
  end
  // ******************************
  // Main sequence
  // ******************************
  initial begin
    rst_n = 1'b0;
    ax = '0;
    ay = '0;
    az = '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (ridx[i]) begin
      HOST.get(ridx[i], d);
      check(d, 8'h00);
    end
    HOST.put(8'h74, 8'hFF);
    HOST.get(8'h74, d);
    check(d, 8'hFC);
    HOST.put(8'h77, 8'hFF);
    HOST.get(8'h77, d);
    check(d, 8'h7F);
    HOST.put(8'h17, 8'h82);
    HOST.put(8'h18, 8'h02);
    foreach (ridx[i]) begin
      if (i >= 3 && i <= 7) begin
        HOST.put(ridx[i], i[0] ? 8'h10 : 8'h01);
      end
    end
    HOST.put(8'h81, 8'h00);
    HOST.put(8'h85, 8'h01);
    foreach (rows[i]) begin
      HOST.put(8'h73, rows[i].pa ? 8'h81 : 8'h01);
      HOST.put(8'h80, rows[i].cfg);
      ax <= ffm_acc_t'(rows[i].x);
      ay <= ffm_acc_t'(rows[i].y);
      az <= ffm_acc_t'(rows[i].z);
      repeat (40) @(posedge mclk);
      check(event_o, rows[i].ev);
    end
    check(irq, 1'b1);
    HOST.put(8'h84, 8'h03);
    HOST.get(8'h84, d);
    check(d, 8'h00);
    check(irq, 1'b0);
    // Decrement mode, target 3, eight cycles a step
    HOST.put(8'h73, 8'h01);
    HOST.put(8'h81, 8'h01);
    HOST.put(8'h17, 8'h02);
    HOST.put(8'h18, 8'h03);
    HOST.put(8'h80, 8'h07);
    ax <= '0;
    wait_ev(n);
    HOST.get(8'h83, d);
    check(d, 8'h03);
    repeat (40) @(posedge mclk);
    HOST.get(8'h83, d);
    check(d, 8'h03);
    check(irq, 1'b1);
    ax <= 14'sd600;
    poll_cnt(8'h03, d);
    check(d, 8'h02);
    check(event_o, 1'b0);
    ax <= '0;
    wait_ev(n);
    HOST.put(8'h17, 8'h82);
    ax <= 14'sd600;
    poll_cnt(8'h03, d);
    check(d, 8'h00);
    // Hybrid at 50 Hz: 128 cycles a step, event on the second step
    HOST.put(8'h81, 8'h24);
    HOST.put(8'h18, 8'h02);
    repeat (300) @(posedge mclk);
    ax <= '0;
    wait_ev(n);
    check(n > 128 && n <= 258, 1'b1);
    // High resolution at 200 Hz: eight cycles a step
    ax <= 14'sd600;
    repeat (300) @(posedge mclk);
    HOST.put(8'h81, 8'h12);
    ax <= '0;
    wait_ev(n);
    check(n > 8 && n <= 18, 1'b1);
    HOST.get(8'h84, d);
    check(d, 8'h03);
    HOST.get(8'h82, d);
    check(d, 8'h03);
    // Reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check(event_o, 1'b0);
    check(irq, 1'b0);
    HOST.get(8'h17, d);
    check(d, 8'h00);
    HOST.get(8'h18, d);
    check(d, 8'h00);
    give_verdict();
  end
endmodule : tb_accel_freefall_motion_detect
`default_nettype wire
